// ===== rtl/brsc_bridge.sv
// bridge end: reset routing, strap capture, interrupt pin control
// assumes glue drives straps and register port on i_sys_clk
`default_nettype none
module brsc_bridge (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // board pins
  brsc_if.bridge bus,
  // status to local logic
  output logic o_irq,
  output logic o_boot_from_proc_bus,
  output logic o_wide_request_drive_option,
  output logic o_proc_bus_in_reset
);
  // ***************************************************************
  // strap selection
  // ***************************************************************
  logic [3:0] cfg;
  logic por_done;
  wire [3:0] live_pins = {bus.irq_n[brsc_pkg::PIN_WIDE], bus.irq_n[brsc_pkg::PIN_BOOT],
                          bus.proc_reset_dir_strap, bus.pci_reset_dir_strap};

  brsc_strap_capture u_capture (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_power_on_reset_n(bus.power_on_reset_n),
    .i_pins(live_pins),
    .o_cfg(cfg),
    .o_por_done(por_done)
  );

  // during power-on reset the pins are live; afterwards the frozen copy rules
  wire frozen = por_done & bus.power_on_reset_n;
  wire [3:0] eff = frozen ? cfg : live_pins;
  wire pci_dir_out = eff[brsc_pkg::CFG_PCI_DIR];
  wire pb_dir_out = eff[brsc_pkg::CFG_PB_DIR];
  wire wide_drive = ~eff[brsc_pkg::CFG_WIDE];
  wire host_mode = pci_dir_out;

  // ***************************************************************
  // reset routing
  // ***************************************************************
  wire por_act = ~bus.power_on_reset_n;
  wire pci_rst_act = ~bus.pci_primary_reset_n;
  wire pci_rst_in = ~pci_dir_out & pci_rst_act;
  wire pci_rst_drive = pci_dir_out & por_act;
  wire proc_bus_reset_n_req = pci_rst_in | por_act;
  wire pb_in_reset = ~bus.proc_bus_reset_n;

  logic pri_oe, sec_oe, pb_oe, wide_oe, wide_hold, rst_q;
  wire next_pri_oe = pci_rst_drive;
  wire next_sec_oe = pci_rst_drive | pci_rst_in;
  wire next_pb_oe = pb_dir_out & proc_bus_reset_n_req;
  // wide request stays low one cycle past reset release
  wire next_wide_oe = pci_dir_out & wide_drive & (pci_rst_drive | wide_hold);
  wire rst_release = rst_q & ~pci_rst_act;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pri_oe <= 1'b0;
      sec_oe <= 1'b0;
      pb_oe <= 1'b0;
      wide_oe <= 1'b0;
      wide_hold <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      pri_oe <= next_pri_oe;
      sec_oe <= next_sec_oe;
      pb_oe <= next_pb_oe;
      wide_oe <= next_wide_oe;
      wide_hold <= pci_rst_drive;
      rst_q <= pci_rst_act;
    end
  end

  assign bus.pri_dev_o = 1'b0;
  assign bus.pri_dev_oe = pri_oe;
  assign bus.sec_dev_o = 1'b0;
  assign bus.sec_dev_oe = sec_oe;
  assign bus.pb_dev_o = 1'b0;
  assign bus.pb_dev_oe = pb_oe;
  assign bus.wide_dev_o = 1'b0;
  assign bus.wide_dev_oe = wide_oe;

  // ***************************************************************
  // interrupt pins
  // ***************************************************************
  logic [5:0] irq_dir;
  logic [5:0] doorbell;
  logic [5:0] irq_oe;
  logic irqa_oe;

  // peripheral operation forces pins 0 and 1 to inputs
  wire [5:0] dir_mask = host_mode ? 6'h3F : ~brsc_pkg::PERIPH_IN_MASK;
  wire [5:0] dir_eff = irq_dir & dir_mask;
  wire [5:0] pci_fwd = {5'h00, host_mode & ~bus.pci_irq_a_n};
  wire [5:0] irq_assert = doorbell | pci_fwd;
  wire pins_live = frozen & ~pb_in_reset;
  wire [5:0] next_irq_oe = dir_eff & irq_assert & {6{pins_live}};
  wire proc_irq = ~host_mode & ~(bus.irq_n[0] & bus.irq_n[1]);
  wire next_irqa_oe = proc_irq & pins_live;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_oe <= 6'h00;
      irqa_oe <= 1'b0;
    end else begin
      irq_oe <= next_irq_oe;
      irqa_oe <= next_irqa_oe;
    end
  end

  assign bus.irq_dev_o = 6'h00;
  assign bus.irq_dev_oe = irq_oe;
  assign bus.irqa_dev_o = 1'b0;
  assign bus.irqa_dev_oe = irqa_oe;

  // ***************************************************************
  // register port
  // ***************************************************************
  logic [3:0] status;
  logic [3:0] enable;
  logic [31:0] rdata;
  logic irq;

  wire hit_dir = bus.reg_addr == brsc_pkg::OFF_IRQ_DIR;
  wire hit_bell = bus.reg_addr == brsc_pkg::OFF_DOORBELL;
  wire hit_stat = bus.reg_addr == brsc_pkg::OFF_STATUS;
  wire hit_clr = bus.reg_addr == brsc_pkg::OFF_CLEAR;
  wire hit_en = bus.reg_addr == brsc_pkg::OFF_ENABLE;
  wire hit_cfg = bus.reg_addr == brsc_pkg::OFF_CONFIG;

  // only an external party can hold the pin low while we release it
  wire ext_pb = pb_in_reset & ~pb_oe;
  wire wide_seen = rst_release & ~wide_drive & ~bus.pci_wide_request_n;
  logic [3:0] events;
  always_comb begin
    events = brsc_pkg::EVT_RST;
    events[brsc_pkg::EVT_PCI_RESET] = pci_rst_in;
    events[brsc_pkg::EVT_EXT_PB_RESET] = ext_pb;
    events[brsc_pkg::EVT_WIDE_SEEN] = wide_seen;
    events[brsc_pkg::EVT_PROC_IRQ] = proc_irq;
  end

  wire [3:0] clr = (bus.reg_wr & hit_clr) ? bus.reg_wdata[3:0] : 4'h0;
  // a set in the clearing cycle survives
  wire [3:0] next_status = (status & ~clr) | events;
  wire [5:0] cfg_view = {pb_in_reset, por_done, cfg};

  logic [31:0] rd_value;
  always_comb begin
    if (hit_dir) begin
      rd_value = {26'h0, irq_dir};
    end else if (hit_bell) begin
      rd_value = {26'h0, doorbell};
    end else if (hit_stat) begin
      rd_value = {28'h0, status};
    end else if (hit_en) begin
      rd_value = {28'h0, enable};
    end else if (hit_cfg) begin
      rd_value = {26'h0, cfg_view};
    end else begin
      rd_value = 32'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_dir <= brsc_pkg::IRQ_DIR_RST;
      doorbell <= brsc_pkg::DOORBELL_RST;
      status <= brsc_pkg::EVT_RST;
      enable <= brsc_pkg::EVT_RST;
      rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      // directions take effect only once power-up is done
      if (bus.reg_wr && hit_dir) begin
        irq_dir <= bus.reg_wdata[5:0];
      end
      if (bus.reg_wr && hit_bell) begin
        doorbell <= bus.reg_wdata[5:0];
      end
      if (bus.reg_wr && hit_en) begin
        enable <= bus.reg_wdata[3:0];
      end
      status <= next_status;
      rdata <= bus.reg_rd ? rd_value : 32'h0;
      irq <= |(next_status & enable);
    end
  end

  assign bus.reg_rdata = rdata;
  assign o_irq = irq;
  assign o_boot_from_proc_bus = cfg[brsc_pkg::CFG_BOOT];
  assign o_wide_request_drive_option = ~cfg[brsc_pkg::CFG_WIDE];
  assign o_proc_bus_in_reset = pb_in_reset;
endmodule : brsc_bridge
`default_nettype wire

// ===== rtl/brsc_glue.sv
// board glue end: straps, reset wiring, irq routing, full-reset latch
// assumes the register port follows a one-cycle strobe master
`default_nettype none
module brsc_glue (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // board pins
  brsc_if.glue bus,
  // board choices
  input wire logic i_host_mode,
  input wire logic i_boot_from_proc_bus,
  input wire logic i_wide_request_drive_option,
  input wire logic i_pci_addr_data_line,
  input wire logic [2:0] i_full_reset_sel,
  // resets and interrupts from the system
  input wire logic i_board_por_n,
  input wire logic i_pci_host_reset_n,
  input wire logic i_cpu_hard_reset_n,
  input wire logic [1:0] i_proc_irq_n,
  input wire logic i_pci_periph_irq_n,
  // register master
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // outputs to the processor
  output logic o_cpu_full_reset_n,
  output logic o_host_cpu_irq_n
);
  // ***************************************************************
  // straps and resets
  // ***************************************************************
  wire por_n = i_host_mode ? i_cpu_hard_reset_n : i_board_por_n;
  assign bus.power_on_reset_n = por_n;
  assign bus.pci_reset_dir_strap = i_host_mode;
  assign bus.proc_reset_dir_strap = ~i_host_mode;
  assign bus.pci_config_select = i_host_mode ? 1'b0 : i_pci_addr_data_line;
  assign bus.pri_glue_o = 1'b0;
  assign bus.pri_glue_oe = ~i_host_mode & ~i_pci_host_reset_n;
  assign bus.pb_glue_o = 1'b0;
  assign bus.pb_glue_oe = ~i_host_mode & ~i_cpu_hard_reset_n;

  // ***************************************************************
  // interrupt pins
  // ***************************************************************
  // pin 1 is left to its pull-up while options are sampled
  wire [5:0] strap_o = {1'b0, i_wide_request_drive_option, i_boot_from_proc_bus, 3'h0};
  wire [5:0] strap_oe = {1'b0, 1'b1, 1'b1, 3'h0};
  wire [5:0] proc_oe = {4'h0, {2{~i_host_mode}} & ~i_proc_irq_n};
  // straps stay driven one cycle past negation, since the bridge captures on the edge that sees it
  logic por_seen;
  wire strap_win = ~por_n | ~por_seen;
  assign bus.irq_glue_o = strap_win ? strap_o : 6'h00;
  assign bus.irq_glue_oe = strap_win ? strap_oe : proc_oe;
  assign bus.irqa_glue_o = 1'b0;
  assign bus.irqa_glue_oe = i_host_mode & ~i_pci_periph_irq_n;

  // ***************************************************************
  // register pass-through
  // ***************************************************************
  assign bus.reg_addr = i_reg_addr;
  assign bus.reg_wdata = i_reg_wdata;
  assign bus.reg_wr = i_reg_wr;
  assign bus.reg_rd = i_reg_rd;
  assign o_reg_rdata = bus.reg_rdata;

  // ***************************************************************
  // full-reset latch
  // ***************************************************************
  // the bridge may tristate the pin mid-pulse, so the count carries on
  brsc_pkg::brsc_fr_state_e state, next_state;
  logic [4:0] cnt;
  logic host_irq;
  wire chosen_low = (i_full_reset_sel < 3'd6) & ~bus.irq_n[i_full_reset_sel];
  wire cnt_done = cnt == 5'(brsc_pkg::FULL_RESET_CYCLES - 1);

  always_comb begin
    next_state = state;
    case (state)
      brsc_pkg::FR_IDLE: begin
        if (chosen_low) next_state = brsc_pkg::FR_HOLD;
      end
      brsc_pkg::FR_HOLD: begin
        if (cnt_done) next_state = brsc_pkg::FR_RELEASE;
      end
      brsc_pkg::FR_RELEASE: begin
        if (!chosen_low) next_state = brsc_pkg::FR_IDLE;
      end
      default: next_state = brsc_pkg::FR_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= brsc_pkg::FR_IDLE;
      cnt <= 5'h00;
      host_irq <= 1'b1;
      por_seen <= 1'b0;
    end else begin
      state <= next_state;
      por_seen <= por_n;
      cnt <= (state == brsc_pkg::FR_HOLD) ? cnt + 5'h01 : 5'h00;
      host_irq <= bus.irq_n[0];
    end
  end

  assign o_cpu_full_reset_n = state != brsc_pkg::FR_HOLD;
  assign o_host_cpu_irq_n = host_irq;
endmodule : brsc_glue
`default_nettype wire

// ===== rtl/brsc_if.sv
// board pins between bridge and glue, plus the register access port
// assumes every pin has a pull-up; any enabled driver wins over it
`default_nettype none
interface brsc_if;
  // resolved pin levels
  logic pci_primary_reset_n;
  logic pci_secondary_reset_n;
  logic proc_bus_reset_n;
  logic [5:0] irq_n;
  logic pci_irq_a_n;
  logic pci_wide_request_n;
  // bridge drivers
  logic pri_dev_o, pri_dev_oe, sec_dev_o, sec_dev_oe, pb_dev_o, pb_dev_oe;
  logic [5:0] irq_dev_o, irq_dev_oe;
  logic irqa_dev_o, irqa_dev_oe, wide_dev_o, wide_dev_oe;
  // glue drivers
  logic pri_glue_o, pri_glue_oe, pb_glue_o, pb_glue_oe;
  logic [5:0] irq_glue_o, irq_glue_oe;
  logic irqa_glue_o, irqa_glue_oe;
  // straps and single-direction pins driven by the glue
  logic pci_reset_dir_strap;
  logic proc_reset_dir_strap;
  logic power_on_reset_n;
  logic pci_config_select;
  // register access
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;

  // wired-and with pull-up: an undriven pin reads high
  assign pci_primary_reset_n = (~pri_dev_oe | pri_dev_o) & (~pri_glue_oe | pri_glue_o);
  assign pci_secondary_reset_n = ~sec_dev_oe | sec_dev_o;
  assign proc_bus_reset_n = (~pb_dev_oe | pb_dev_o) & (~pb_glue_oe | pb_glue_o);
  assign irq_n = (~irq_dev_oe | irq_dev_o) & (~irq_glue_oe | irq_glue_o);
  assign pci_irq_a_n = (~irqa_dev_oe | irqa_dev_o) & (~irqa_glue_oe | irqa_glue_o);
  assign pci_wide_request_n = ~wide_dev_oe | wide_dev_o;

  modport bridge (
    input pci_primary_reset_n, proc_bus_reset_n, irq_n, pci_irq_a_n, pci_wide_request_n,
    input pci_reset_dir_strap, proc_reset_dir_strap, power_on_reset_n, pci_config_select,
    input reg_addr, reg_wdata, reg_wr, reg_rd,
    output pri_dev_o, pri_dev_oe, sec_dev_o, sec_dev_oe, pb_dev_o, pb_dev_oe,
    output irq_dev_o, irq_dev_oe, irqa_dev_o, irqa_dev_oe, wide_dev_o, wide_dev_oe,
    output reg_rdata
  );
  modport glue (
    input pci_primary_reset_n, pci_secondary_reset_n, proc_bus_reset_n, irq_n, pci_irq_a_n,
    input reg_rdata,
    output pri_glue_o, pri_glue_oe, pb_glue_o, pb_glue_oe, irq_glue_o, irq_glue_oe,
    output irqa_glue_o, irqa_glue_oe,
    output pci_reset_dir_strap, proc_reset_dir_strap, power_on_reset_n, pci_config_select,
    output reg_addr, reg_wdata, reg_wr, reg_rd
  );
endinterface : brsc_if
`default_nettype wire

// ===== rtl/brsc_pkg.sv
// constants shared by the bridge reset/strap end and the board glue end
// assumes one 25 MHz clock and active-low open-drain style board pins
//
// Operation
// - pci reset input propagates to proc bus, secondary
// - low pci strap: receive and propagate pci reset
// - high proc strap: bridge drives proc bus reset
// - always monitor proc bus reset pin
// - high pci strap: power-on reset drives pci resets
// - boot source sampled from irq pin 3
// - wide request option sampled from irq pin 4
// - board holds irq pin 1 high at sampling
// - nobody drives irq pin 1 during power-up
// - host software sets irq pin directions at 0x444
// - irq outputs tristate during proc bus reset
// - glue latches irq output into cpu full reset
// - doorbell write asserts its mapped irq pin
// - peripheral: config select tied to address line
// - host: config select tied low
// - peripheral: irq 0,1 inputs, pci irq a output
// - host: irq 0 output, pci irq a input
// - peripheral: proc bus reset wired to cpu hard reset
`default_nettype none
package brsc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 6;
  // register byte offsets
  localparam logic [11:0] OFF_IRQ_DIR = 12'h444;
  localparam logic [11:0] OFF_DOORBELL = 12'h448;
  localparam logic [11:0] OFF_STATUS = 12'h44C;
  localparam logic [11:0] OFF_CLEAR = 12'h450;
  localparam logic [11:0] OFF_ENABLE = 12'h454;
  localparam logic [11:0] OFF_CONFIG = 12'h458;
  // reset values
  localparam logic [5:0] IRQ_DIR_RST = 6'h00;
  localparam logic [5:0] DOORBELL_RST = 6'h00;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [3:0] CFG_RST = 4'h0;
  // status / event bits
  localparam int EVT_PCI_RESET = 0;
  localparam int EVT_EXT_PB_RESET = 1;
  localparam int EVT_WIDE_SEEN = 2;
  localparam int EVT_PROC_IRQ = 3;
  localparam int EVT_W = 4;
  // captured strap vector fields
  localparam int CFG_PCI_DIR = 0;
  localparam int CFG_PB_DIR = 1;
  localparam int CFG_BOOT = 2;
  localparam int CFG_WIDE = 3;
  localparam int CFG_W = 4;
  // irq pins that carry options
  localparam int PIN_SYS_MODE = 1;
  localparam int PIN_BOOT = 3;
  localparam int PIN_WIDE = 4;
  // pins forced to inputs in peripheral operation
  localparam logic [5:0] PERIPH_IN_MASK = 6'h03;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FULL_RESET_TIME_NS = 1000;
  localparam int FULL_RESET_CYCLES = (FULL_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FR_CNT_W = 5;
  // glue full-reset latch states, gray from idle through hold to release
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_HOLD = 2'b01,
    FR_RELEASE = 2'b11
  } brsc_fr_state_e;
endpackage : brsc_pkg
`default_nettype wire

// ===== rtl/brsc_strap_capture.sv
// strap capture: freezes option pins at power-on reset negation
// assumes option pins are steady around that edge
`default_nettype none
module brsc_strap_capture (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // pins
  input wire logic i_power_on_reset_n,
  input wire logic [3:0] i_pins,
  // captured values
  output logic [3:0] o_cfg,
  output logic o_por_done
);
  logic por_q;
  logic [3:0] cfg;
  logic done;
  wire negation = ~por_q & i_power_on_reset_n;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_q <= 1'b0;
      cfg <= brsc_pkg::CFG_RST;
      done <= 1'b0;
    end else begin
      por_q <= i_power_on_reset_n;
      if (negation) begin
        cfg <= i_pins;
      end
      // a fresh power-on reset reopens the window
      done <= i_power_on_reset_n & (done | negation);
    end
  end

  assign o_cfg = cfg;
  assign o_por_done = done;
endmodule : brsc_strap_capture
`default_nettype wire

// ===== verification/brsc_properties.sv
// checker: pin and register-port relations between bridge and glue
// assumes it sits beside the interface that joins both ends
`default_nettype none
module brsc_properties (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // resolved pins and straps
  input wire logic pci_primary_reset_n,
  input wire logic pci_secondary_reset_n,
  input wire logic proc_bus_reset_n,
  input wire logic [5:0] irq_n,
  input wire logic power_on_reset_n,
  input wire logic pci_reset_dir_strap,
  input wire logic proc_reset_dir_strap,
  // drivers
  input wire logic [5:0] irq_dev_oe,
  input wire logic [5:0] irq_glue_oe,
  input wire logic irqa_dev_oe,
  input wire logic pri_dev_oe,
  input wire logic wide_dev_oe,
  input wire logic wide_dev_o,
  // register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  por_drive_a: assert property (pci_reset_dir_strap && !power_on_reset_n
    |=> !pci_primary_reset_n && !pci_secondary_reset_n) else $error("pci resets not driven");
  pci_prop_a: assert property (!pci_reset_dir_strap && !pci_primary_reset_n
    |=> !pci_secondary_reset_n) else $error("secondary reset not propagated");
  pb_drive_a: assert property (proc_reset_dir_strap && !pci_reset_dir_strap && !pci_primary_reset_n
    |=> !proc_bus_reset_n) else $error("proc bus reset not driven");
  irq_tristate_a: assert property (!proc_bus_reset_n |=> irq_dev_oe == 6'h00 && !irqa_dev_oe)
    else $error("irq driven during proc bus reset");
  periph_nodrive_a: assert property (!pci_reset_dir_strap && power_on_reset_n
    && $past(power_on_reset_n) |-> !pri_dev_oe) else $error("pci reset driven as receiver");
  periph_inputs_a: assert property (!pci_reset_dir_strap && power_on_reset_n
    && $past(power_on_reset_n) |-> irq_dev_oe[1:0] == 2'b00) else $error("irq 0/1 not inputs");
  wide_window_a: assert property (wide_dev_oe |-> !wide_dev_o
    && (pri_dev_oe || $past(pri_dev_oe))) else $error("wide request outside reset");
  opt_pin_a: assert property (!power_on_reset_n && !$past(power_on_reset_n)
    |-> irq_n[1] && !irq_glue_oe[1]) else $error("option pin 1 not left high");
endmodule : brsc_properties
`default_nettype wire

// ===== verification/test_bridge_reset_strap_config.sv
// bench: bridge and glue joined by the interface, register model in ints
// assumes the glue drives straps and register port from its inputs
`default_nettype none
module test_bridge_reset_strap_config;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // signals and instances
  // ****************
  logic i_sys_clk, i_rstn, host, boot, wide, adl, por_n, phr_n, chr_n, ppirq_n, wr, rd;
  logic [1:0] pirq_n;
  logic [2:0] sel;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic irq, o_boot, o_wide, pbr, cfr_n, hirq_n;
  int err_total, check_count, cnt, k, m_dir;
  brsc_if bus();
  brsc_bridge brsc_bridge_i (.i_sys_clk, .i_rstn, .bus(bus), .o_irq(irq), .o_boot_from_proc_bus(o_boot),
    .o_wide_request_drive_option(o_wide), .o_proc_bus_in_reset(pbr));
  brsc_glue brsc_glue_i (.i_sys_clk, .i_rstn, .bus(bus), .i_host_mode(host), .i_boot_from_proc_bus(boot),
    .i_wide_request_drive_option(wide), .i_pci_addr_data_line(adl), .i_full_reset_sel(sel),
    .i_board_por_n(por_n), .i_pci_host_reset_n(phr_n), .i_cpu_hard_reset_n(chr_n), .i_proc_irq_n(pirq_n),
    .i_pci_periph_irq_n(ppirq_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_cpu_full_reset_n(cfr_n), .o_host_cpu_irq_n(hirq_n));
  brsc_properties brsc_properties_i (.i_sys_clk, .i_rstn,
    .pci_primary_reset_n(bus.pci_primary_reset_n), .pci_secondary_reset_n(bus.pci_secondary_reset_n),
    .proc_bus_reset_n(bus.proc_bus_reset_n), .irq_n(bus.irq_n), .power_on_reset_n(bus.power_on_reset_n),
    .pci_reset_dir_strap(bus.pci_reset_dir_strap), .proc_reset_dir_strap(bus.proc_reset_dir_strap),
    .irq_dev_oe(bus.irq_dev_oe), .irq_glue_oe(bus.irq_glue_oe), .irqa_dev_oe(bus.irqa_dev_oe),
    .pri_dev_oe(bus.pri_dev_oe), .wide_dev_oe(bus.wide_dev_oe), .wide_dev_o(bus.wide_dev_o),
    .reg_rd(bus.reg_rd), .reg_rdata(bus.reg_rdata));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
    if (a == brsc_pkg::OFF_IRQ_DIR) m_dir = d & 32'h3F;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe, so look at the falling edge there
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    @(negedge i_sys_clk);
    chk(rdata, e);
  endtask : rd_reg
  task automatic power_up(input logic h, input logic b, input logic w);
    @(posedge i_sys_clk);
    por_n <= 1'b0;
    chr_n <= 1'b0;
    host <= h;
    boot <= b;
    wide <= w;
    repeat (4) @(negedge i_sys_clk);
    if (h) begin
      chk(bus.pci_primary_reset_n, 1'b0);
      chk(bus.pci_secondary_reset_n, 1'b0);
    end
    @(posedge i_sys_clk);
    por_n <= 1'b1;
    chr_n <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk(o_boot, b);
    chk(o_wide, !w);
    @(posedge i_sys_clk);
    boot <= !b;
    wide <= !w;
    repeat (2) @(negedge i_sys_clk);
    chk(o_boot, b);
    chk(o_wide, !w);
  endtask : power_up
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ****************
  // clock, watchdog, sequence
  // ****************
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #800000;
    err_total++;
    stop_test;
  end
  initial begin
    {i_rstn, host, boot, wr, rd} = 5'h00;
    {wide, adl, por_n, phr_n, chr_n, ppirq_n} = 6'h3F;
    pirq_n = 2'h3;
    sel = 3'h2;
    addr = 12'h000;
    wdata = 32'h0;
    {err_total, check_count, m_dir} = '0;
    void'($urandom(32'h26B9CD98));
    repeat (8) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd_reg(brsc_pkg::OFF_IRQ_DIR, 32'h0);
    rd_reg(12'h000, 32'h0);
    // peripheral card: pci host reset fans out to proc bus and secondary
    power_up(1'b0, 1'b0, 1'b1);
    chk(bus.pci_config_select, adl);
    @(posedge i_sys_clk);
    phr_n <= 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(bus.pci_secondary_reset_n, 1'b0);
    chk(bus.pri_dev_oe, 1'b0);
    chk(bus.proc_bus_reset_n, 1'b0);
    chk(pbr, 1'b1);
    @(posedge i_sys_clk);
    phr_n <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk(bus.proc_bus_reset_n, 1'b1);
    wr_reg(brsc_pkg::OFF_CLEAR, 32'hF);
    @(posedge i_sys_clk);
    pirq_n <= 2'b01;
    for (k = 0; k < 8 && bus.pci_irq_a_n !== 1'b0; k++) @(negedge i_sys_clk);
    chk(bus.pci_irq_a_n, 1'b0);
    rd_reg(brsc_pkg::OFF_STATUS, 32'h8);
    @(posedge i_sys_clk);
    pirq_n <= 2'b11;
    // doorbell on pin 2 starts the latched full reset; pins 0/1 must stay inputs
    wr_reg(brsc_pkg::OFF_IRQ_DIR, 32'h7);
    wr_reg(brsc_pkg::OFF_DOORBELL, 32'h7);
    for (k = 0; k < 8 && cfr_n !== 1'b0; k++) @(negedge i_sys_clk);
    chk(bus.irq_n[2:0], 3'b011);
    cnt = 0;
    while (cfr_n === 1'b0 && cnt < 40) begin
      @(negedge i_sys_clk);
      cnt++;
    end
    chk(cnt, brsc_pkg::FULL_RESET_CYCLES);
    // external proc bus reset: monitored, tristates irqs, raises a maskable event
    wr_reg(brsc_pkg::OFF_ENABLE, 32'h2);
    wr_reg(brsc_pkg::OFF_CLEAR, 32'hF);
    @(posedge i_sys_clk);
    chr_n <= 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(pbr, 1'b1);
    chk(bus.proc_bus_reset_n, 1'b0);
    chk(bus.irq_n[2], 1'b1);
    chk(irq, 1'b1);
    wr_reg(brsc_pkg::OFF_ENABLE, 32'h0);
    repeat (2) @(negedge i_sys_clk);
    chk(irq, 1'b0);
    @(posedge i_sys_clk);
    chr_n <= 1'b1;
    rd_reg(brsc_pkg::OFF_STATUS, 32'h2);
    wr_reg(brsc_pkg::OFF_CLEAR, 32'h2);
    rd_reg(brsc_pkg::OFF_STATUS, 32'h0);
    wr_reg(brsc_pkg::OFF_DOORBELL, 32'h0);
    wr_reg(brsc_pkg::OFF_IRQ_DIR, 32'h0);
    // host bridge: every boot/wide option pair, random pin directions
    for (int i = 0; i < 4; i++) begin
      power_up(1'b1, i[0], i[1]);
      chk(bus.pci_config_select, 1'b0);
      wr_reg(brsc_pkg::OFF_IRQ_DIR, $urandom & 32'h3F);
      rd_reg(brsc_pkg::OFF_IRQ_DIR, m_dir);
    end
    wr_reg(brsc_pkg::OFF_IRQ_DIR, 32'h1);
    @(posedge i_sys_clk);
    ppirq_n <= 1'b0;
    for (k = 0; k < 8 && hirq_n !== 1'b0; k++) @(negedge i_sys_clk);
    chk(hirq_n, 1'b0);
    @(posedge i_sys_clk);
    ppirq_n <= 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk(hirq_n, 1'b1);
    stop_test;
  end
endmodule : test_bridge_reset_strap_config
`default_nettype wire
